// File: include/gcg_map.svh
// register offsets, field positions, reset values and limits of the
// generic clock generator block; assumes a 32-bit apb slave port.
//
// Notes on behaviour
// [RULE_01] off or pin disabled: pin shows idle level
// [RULE_02] duty balance gives 50/50 on odd factors
// [RULE_03] generator runs only while generator_on set
// [RULE_04] reserved bits read zero; software writes zeros
// [RULE_05] source_select codes 0..8 pick input clock
// [RULE_06] setup index picks generator 0..5
// [RULE_07] software writes divider as one full word
// [RULE_08] index-only write picks divider read target
// [RULE_09] factor bits above generator width are dropped
// [RULE_10] widths: 8, 16, 5, then 8 bits
// [RULE_11] divider index picks written generator 0..5
// [RULE_12] power reset restores every setup
// [RULE_13] power defaults: gen0 on/fast, gen2 on/ulp
// [RULE_14] user reset spares rtc and locked sources; code resets gen0 even so
// [RULE_15] power reset clears every divider
// [RULE_16] user reset clears spared dividers never; code clears the gen0 divider even so
// [RULE_17] style 0 divides by factor, 1 by 2^(f+1)
// [RULE_18] pin enable drives pin unless pin is source
`ifndef GCG_MAP_SVH
`define GCG_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define GCG_SETUP_OFF   12'h004
`define GCG_DIV_OFF     12'h008

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define GCG_IDX_LSB     0
`define GCG_SRC_LSB     8
`define GCG_ON_BIT      16
`define GCG_BAL_BIT     17
`define GCG_IDLE_BIT    18
`define GCG_PINEN_BIT   19
`define GCG_STYLE_BIT   20
`define GCG_STBY_BIT    21
`define GCG_DIV_LSB     8

// ----------------------------------------------------------------
// source codes and counts
// ----------------------------------------------------------------
`define GCG_SRC_XOSC    5'h00
`define GCG_SRC_PAD     5'h01
`define GCG_SRC_GEN1    5'h02
`define GCG_SRC_ULP     5'h03
`define GCG_SRC_LAST    5'h08
`define GCG_GEN_NUM     6
`define GCG_GEN_LIMIT   4'h6
`define GCG_STRB_FULL   4'hf
`define GCG_EXP_MAX     5'h1e

// ----------------------------------------------------------------
// divider widths and power reset values
// ----------------------------------------------------------------
`define GCG_DIV_W0      8
`define GCG_DIV_W1      16
`define GCG_DIV_W2      5
`define GCG_DIV_WREST   8
`define GCG_GEN0_SRC    5'h06
`define GCG_GEN2_SRC    5'h03

`endif

// File: include/gcg_pkg.sv
// types shared by the generic clock generator design files;
// assumes gcg_map.svh sits on the include path.
package gcg_pkg;
`include "gcg_map.svh"

    typedef struct packed {
        logic       run_standby;
        logic       divide_style;
        logic       pin_enable;
        logic       pin_idle_level;
        logic       duty_balance;
        logic       generator_on;
        logic [4:0] source_select;
    } gcg_setup_t;

    typedef struct packed {
        gcg_setup_t [5:0]       setup;
        logic       [5:0][15:0] factor;
        logic       [3:0]       setup_ptr;
        logic       [3:0]       div_ptr;
        logic                   pready;
        logic                   pslverr;
        logic       [31:0]      prdata;
        logic       [6:0]       osc_meta;
        logic       [6:0]       osc_sync;
        logic       [5:0]       pad_meta;
        logic       [5:0]       pad_sync;
        logic       [5:0]       pin_out;
        logic       [5:0]       pin_oe_n;
        logic       [5:0]       gen_clk;
    } gcg_state_t;

    typedef struct packed {
        logic        prev;
        logic        out;
        logic [31:0] count;
    } gcg_div_state_t;

    function automatic gcg_setup_t gcg_setup_default(input int g);
        gcg_setup_t s;
        s = '0;
        if (g == 0) begin
            s.generator_on  = 1'b1;
            s.source_select = `GCG_GEN0_SRC;
        end else if (g == 2) begin
            s.generator_on  = 1'b1;
            s.source_select = `GCG_GEN2_SRC;
        end
        return s;
    endfunction

    function automatic gcg_state_t gcg_power_state();
        gcg_state_t s;
        s = '0;
        for (int g = 0; g < `GCG_GEN_NUM; g++) begin
            s.setup[g] = gcg_setup_default(g);
        end
        return s;
    endfunction

    function automatic logic [15:0] gcg_div_mask(input int g);
        int w;
        w = (g == 0) ? `GCG_DIV_W0 :
            (g == 1) ? `GCG_DIV_W1 :
            (g == 2) ? `GCG_DIV_W2 : `GCG_DIV_WREST;
        return 16'((32'h1 << w) - 32'h1);
    endfunction
endpackage

// File: design/gcg_divider.sv
// one generator divider, counting edges of an already synchronised
// source level; assumes the source is far slower than pclk.
`timescale 1ns/10ps
`default_nettype none
`include "gcg_map.svh"

module gcg_divider
    import gcg_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        src_level,
    input  wire logic        enable,
    input  wire logic        divide_style,
    input  wire logic        duty_balance,
    input  wire logic [15:0] factor,
    output logic             clk_out
);

    gcg_div_state_t st;
    gcg_div_state_t next_st;
    logic [31:0]    ratio;
    logic [4:0]     expo;
    logic           odd_even;
    logic           rise;
    logic           fall;
    logic           step;
    logic           wrap;

    // ----------------------------------------------------------------
    // ratio and edge counting
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;
        // exponent clamped so the ratio stays inside 32 bits
        expo = (factor > 16'(`GCG_EXP_MAX)) ? `GCG_EXP_MAX : factor[4:0];
        if (divide_style) begin
            ratio = 32'h1 << (expo + 5'h1); // RULE_17
        end else if (factor < 16'h0002) begin
            ratio = 32'h1; // RULE_17
        end else begin
            ratio = {16'h0, factor}; // RULE_17
        end
        odd_even = duty_balance & ratio[0];
        rise = src_level & ~st.prev;
        fall = ~src_level & st.prev;
        // balanced odd ratios count both edges, half period = ratio
        step = odd_even ? (rise | fall) : rise; // RULE_02
        // a ratio cut below the running count must still wrap
        wrap = (st.count >= ratio - 32'h1);
        next_st.prev = src_level;
        if (!enable) begin
            next_st.count = '0; // RULE_03
            next_st.out   = 1'b0;
        end else if (ratio == 32'h1) begin
            next_st.count = '0;
            next_st.out   = src_level;
        end else if (step) begin
            next_st.count = wrap ? 32'h0 : st.count + 32'h1;
            if (odd_even) begin
                if (wrap) begin
                    next_st.out = ~st.out; // RULE_02
                end
            end else begin
                next_st.out = (next_st.count < (ratio >> 1));
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign clk_out = st.out;

endmodule
`default_nettype wire

// File: design/gcg_top.sv
// six generic clock generators with indexed setup and divider
// registers behind an apb slave; assumes oscillator and pad inputs
// are asynchronous levels well below half the pclk rate.
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "gcg_map.svh"

module gcg_top
    import gcg_pkg::*;
#(
    parameter int ADDR_W = 12
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              user_reset,
    input  wire logic [3:0]        rtc_generator,
    input  wire logic [5:0]        write_lock_source,
    input  wire logic [6:0]        osc_clk,
    input  wire logic [5:0]        generator_pin_in,
    output logic      [5:0]        generator_pin_out,
    output logic      [5:0]        generator_pin_oe_n,
    output logic      [5:0]        gen_clk
);

    localparam gcg_state_t POWER_STATE = gcg_power_state();
    localparam int         NG          = `GCG_GEN_NUM;

    gcg_state_t  st;
    gcg_state_t  next_st;
    logic [5:0]  sel_level;
    logic [5:0]  div_out;
    logic        hit_setup;
    logic        hit_div;
    logic        access;
    logic        done;
    logic [3:0]  wr_idx;
    logic        full_word;
    logic [31:0] rd_word;
    logic [2:0]  rp;
    logic [2:0]  wp;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    assign hit_setup = (paddr == ADDR_W'(`GCG_SETUP_OFF));
    assign hit_div   = (paddr == ADDR_W'(`GCG_DIV_OFF));
    assign access    = psel & penable;
    // the transfer ends on the edge that samples pready high
    assign done      = access & st.pready;
    assign wr_idx    = pwdata[`GCG_IDX_LSB +: 4];
    assign full_word = (pstrb == `GCG_STRB_FULL);
    // write slot kept apart from the read slot: one driver each
    assign wp        = wr_idx[2:0];

    // ----------------------------------------------------------------
    // source selection per generator
    // ----------------------------------------------------------------
    always_comb begin
        sel_level = '0;
        for (int g = 0; g < NG; g++) begin
            case (st.setup[g].source_select) // RULE_05
                `GCG_SRC_XOSC: sel_level[g] = st.osc_sync[0];
                `GCG_SRC_PAD:  sel_level[g] = st.pad_sync[g];
                `GCG_SRC_GEN1: sel_level[g] = div_out[1];
                5'h03:         sel_level[g] = st.osc_sync[1];
                5'h04:         sel_level[g] = st.osc_sync[2];
                5'h05:         sel_level[g] = st.osc_sync[3];
                5'h06:         sel_level[g] = st.osc_sync[4];
                5'h07:         sel_level[g] = st.osc_sync[5];
                `GCG_SRC_LAST: sel_level[g] = st.osc_sync[6];
                // reserved codes leave the generator without a clock
                default:       sel_level[g] = 1'b0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // dividers
    // ----------------------------------------------------------------
    generate
        for (genvar g = 0; g < NG; g++) begin : gen_div
            gcg_divider u_div (
                .pclk         (pclk),
                .presetn      (presetn),
                .src_level    (sel_level[g]),
                .enable       (st.setup[g].generator_on),
                .divide_style (st.setup[g].divide_style),
                .duty_balance (st.setup[g].duty_balance),
                .factor       (st.factor[g]),
                .clk_out      (div_out[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // read data for the pending access
    // ----------------------------------------------------------------
    always_comb begin
        rd_word = '0; // RULE_04
        rp      = 3'h0;
        if (hit_setup) begin
            rd_word[`GCG_IDX_LSB +: 4] = st.setup_ptr;
            rp = st.setup_ptr[2:0];
            if (st.setup_ptr < `GCG_GEN_LIMIT) begin // RULE_06
                rd_word[`GCG_SRC_LSB +: 5] = st.setup[rp].source_select;
                rd_word[`GCG_ON_BIT]    = st.setup[rp].generator_on;
                rd_word[`GCG_BAL_BIT]   = st.setup[rp].duty_balance;
                rd_word[`GCG_IDLE_BIT]  = st.setup[rp].pin_idle_level;
                rd_word[`GCG_PINEN_BIT] = st.setup[rp].pin_enable;
                rd_word[`GCG_STYLE_BIT] = st.setup[rp].divide_style;
                rd_word[`GCG_STBY_BIT]  = st.setup[rp].run_standby;
            end
        end else if (hit_div) begin
            rd_word[`GCG_IDX_LSB +: 4] = st.div_ptr;
            rp = st.div_ptr[2:0];
            if (st.div_ptr < `GCG_GEN_LIMIT) begin
                rd_word[`GCG_DIV_LSB +: 16] = st.factor[rp]; // RULE_08
            end
        end
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;

        // input synchronisers; stage one feeds stage two only
        next_st.osc_meta = osc_clk;
        next_st.osc_sync = st.osc_meta;
        next_st.pad_meta = generator_pin_in;
        next_st.pad_sync = st.pad_meta;

        // one wait state; answer word fixed at that point
        next_st.pready  = access & ~st.pready;
        next_st.pslverr = 1'b0;
        next_st.prdata  = '0;
        if (access & ~st.pready) begin
            next_st.pslverr = ~(hit_setup | hit_div);
            if (!pwrite) begin
                next_st.prdata = rd_word;
            end
        end

        if (done & pwrite & hit_setup) begin
            if (pstrb[0]) begin
                next_st.setup_ptr = wr_idx; // RULE_06
            end
            // only a whole word carries a configuration
            if (full_word && wr_idx < `GCG_GEN_LIMIT) begin
                next_st.setup[wp].source_select =
                    pwdata[`GCG_SRC_LSB +: 5]; // RULE_05
                next_st.setup[wp].generator_on =
                    pwdata[`GCG_ON_BIT]; // RULE_03
                next_st.setup[wp].duty_balance =
                    pwdata[`GCG_BAL_BIT]; // RULE_02
                next_st.setup[wp].pin_idle_level =
                    pwdata[`GCG_IDLE_BIT]; // RULE_01
                next_st.setup[wp].pin_enable =
                    pwdata[`GCG_PINEN_BIT]; // RULE_18
                next_st.setup[wp].divide_style =
                    pwdata[`GCG_STYLE_BIT]; // RULE_17
                next_st.setup[wp].run_standby =
                    pwdata[`GCG_STBY_BIT];
            end
        end

        if (done & pwrite & hit_div) begin
            if (pstrb[0]) begin
                next_st.div_ptr = wr_idx; // RULE_08
            end
            // a partial write only moves the read pointer
            if (full_word && wr_idx < `GCG_GEN_LIMIT) begin // RULE_07
                for (int g = 0; g < NG; g++) begin
                    if (wr_idx == 4'(g)) begin // RULE_11
                        next_st.factor[g] =
                            pwdata[`GCG_DIV_LSB +: 16] &
                            gcg_div_mask(g); // RULE_09 RULE_10
                    end
                end
            end
        end

        // user reset wins over a bus write in the same cycle
        if (user_reset) begin
            next_st.setup_ptr = '0;
            next_st.div_ptr   = '0;
            for (int g = 0; g < NG; g++) begin
                if (g == 0 ||
                    !(rtc_generator == 4'(g) ||
                      write_lock_source[g])) begin
                    next_st.setup[g]  = gcg_setup_default(g); // RULE_14
                    next_st.factor[g] = '0; // RULE_16
                end
            end
        end

        // pin and generator outputs
        for (int g = 0; g < NG; g++) begin
            next_st.gen_clk[g] = div_out[g];
            if (st.setup[g].source_select == `GCG_SRC_PAD) begin
                // pad is this generator's input: release it
                next_st.pin_oe_n[g] = 1'b1; // RULE_18
                next_st.pin_out[g]  = 1'b0;
            end else begin
                next_st.pin_oe_n[g] = 1'b0;
                if (st.setup[g].generator_on &&
                    st.setup[g].pin_enable) begin
                    next_st.pin_out[g] = div_out[g]; // RULE_18
                end else begin
                    next_st.pin_out[g] =
                        st.setup[g].pin_idle_level; // RULE_01
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // power reset restores every generator, rtc source too
            st <= POWER_STATE; // RULE_12 RULE_13 RULE_15
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata             = st.prdata;
    assign pready             = st.pready;
    assign pslverr            = st.pslverr;
    assign generator_pin_out  = st.pin_out;
    assign generator_pin_oe_n = st.pin_oe_n;
    assign gen_clk            = st.gen_clk;

endmodule
`default_nettype wire

// File: verification/gcg_top_props.sv
// concurrent checks on the apb and pad ports of gcg_top
// assumes one pclk domain and presetn as the only reset
`timescale 1ns/10ps
`default_nettype none
`include "gcg_map.svh"
module gcg_top_chk #(
    parameter int ADDR_W = 12
)
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [5:0]        generator_pin_out,
    input wire logic [5:0]        generator_pin_oe_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_set = pready && !pwrite && paddr == `GCG_SETUP_OFF;
    wire rd_div = pready && !pwrite && paddr == `GCG_DIV_OFF;
    // ------------------------------------------------------------
    // bus answer
    // ------------------------------------------------------------
    a_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not one cycle after access start");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_err_map: assert property (pready |->
        pslverr == (paddr != `GCG_SETUP_OFF && paddr != `GCG_DIV_OFF))
        else $error("pslverr does not match address map");
    a_idle_rdata: assert property (!pready || pwrite || pslverr |-> prdata == 32'h0)
        else $error("read data outside a read answer");
    // ------------------------------------------------------------
    // register contents
    // ------------------------------------------------------------
    a_setup_resv: assert property (rd_set |-> prdata[31:22] == 10'h0 &&
        prdata[15:13] == 3'h0 && prdata[7:4] == 4'h0)
        else $error("setup reserved bits not zero");
    a_div_resv: assert property (rd_div |->
        prdata[31:24] == 8'h0 && prdata[7:4] == 4'h0)
        else $error("divider reserved bits not zero");
    a_div_width: assert property (rd_div && prdata[3:0] != 4'h1 |->
        prdata[23:16] == 8'h0 && (prdata[3:0] != 4'h2 || prdata[15:13] == 3'h0))
        else $error("divider factor wider than generator");
    a_bad_index: assert property ((rd_set || rd_div) && prdata[3:0] > 4'h5
        |-> prdata[31:4] == 28'h0)
        else $error("reserved index returned settings");
    a_pad_quiet: assert property ((generator_pin_oe_n & generator_pin_out) == 6'h0)
        else $error("released pad carries a value");
    c_div_read: cover property (rd_div && prdata[23:8] != 16'h0);
    c_set_read: cover property (rd_set && prdata[16]);
    c_err: cover property (pslverr);
    c_pad_in: cover property (generator_pin_oe_n != 6'h0);
endmodule
bind gcg_top gcg_top_chk #(.ADDR_W(ADDR_W)) i_chk (.pclk(pclk),
    .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .generator_pin_out(generator_pin_out),
    .generator_pin_oe_n(generator_pin_oe_n));
`default_nettype wire

// File: verification/tb_top.sv
// self-checking bench for gcg_top: registers, resets, generator outputs
// assumes gcg_pkg compiled first and gcg_map.svh on the include path
`timescale 1ns/10ps
`default_nettype none
`include "gcg_map.svh"
module tb_top;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, user_reset, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, d, es [6], ed [6];
    logic [3:0]  pstrb, rtc_generator;
    logic [5:0]  write_lock_source, generator_pin_in, pin_out, pin_oe_n, gen_clk;
    logic [6:0]  osc_clk;
    logic [32:0] q [$];
    logic        lg, lp;
    int          miscompares = 0, tests_run = 0, cyc = 0, rg, rp, hi, e, r;
    int          rat [5] = '{4, 4, 2, 3, 0};
    logic [7:0]  fac [5] = '{8'h04, 8'h01, 8'h00, 8'h03, 8'h04};

    gcg_top #(.ADDR_W(12)) i_dut (.pclk(pclk), .presetn(presetn),
        .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .user_reset(user_reset),
        .rtc_generator(rtc_generator), .write_lock_source(write_lock_source),
        .osc_clk(osc_clk), .generator_pin_in(generator_pin_in),
        .generator_pin_out(pin_out), .generator_pin_oe_n(pin_oe_n),
        .gen_clk(gen_clk));

    always #4 pclk = ~pclk;
    // sources toggle every 8 cycles, well under the pclk/2 limit
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc % 8 == 7) begin
            osc_clk <= ~osc_clk;
            generator_pin_in <= ~generator_pin_in;
        end
        if (cyc == 40000) begin
            miscompares++;
            conclude();
        end
    end
    // ------------------------------------------------------------
    // answer watcher: oldest note against each bus answer
    // ------------------------------------------------------------
    always @(posedge pclk)
        if (pready === 1'b1) begin
            if (q.size() == 0) check("extra", 33'h1, 33'h0);
            else check("apb", {pslverr, prdata}, q.pop_front());
        end

    task automatic check(input string n, input logic [32:0] s, e);
        tests_run++;
        if (s !== e) begin
            miscompares++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic apb(input logic [11:0] a, input logic w,
                       input logic [31:0] wd, input logic [3:0] s,
                       input logic [32:0] x);
        q.push_back(x);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= wd;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    function automatic logic [31:0] dflt(input int g);
        return g == 0 ? 32'h00010600 : g == 2 ? 32'h00010302 : 32'(g);
    endfunction

    task automatic rd_all;
        for (int g = 0; g < 6; g++) begin
            apb(`GCG_SETUP_OFF, 1'b1, 32'(g), 4'h1, 33'h0);
            apb(`GCG_SETUP_OFF, 1'b0, 32'h0, 4'hf, {1'b0, es[g]});
            apb(`GCG_DIV_OFF, 1'b1, 32'(g), 4'h1, 33'h0);
            apb(`GCG_DIV_OFF, 1'b0, 32'h0, 4'hf, {1'b0, ed[g]});
        end
    endtask

    task automatic power_reset;
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int g = 0; g < 6; g++) begin
            es[g] = dflt(g);
            ed[g] = 32'(g);
        end
    endtask

    initial begin
        {presetn, psel, penable, pwrite, user_reset} = 5'h0;
        {paddr, pwdata, pstrb, rtc_generator} = '0;
        {write_lock_source, generator_pin_in, osc_clk} = '0;
        void'($urandom(32'h086b));
        @(posedge pclk);
        power_reset();
        rd_all();
        // ------------------------------------------------------------
        // random full-word configuration of every generator
        // ------------------------------------------------------------
        for (int g = 0; g < 6; g++) begin
            d = $urandom & 32'h003f1f0f;
            d[3:0] = 4'(g);
            d[12:8] = 5'($urandom % 9);
            apb(`GCG_SETUP_OFF, 1'b1, d, 4'hf, 33'h0);
            es[g] = d & 32'h003f1f0f;
            d = $urandom & 32'h00ffff0f;
            d[3:0] = 4'(g);
            apb(`GCG_DIV_OFF, 1'b1, d, 4'hf, 33'h0);
            ed[g] = {8'h0, d[23:8] & (g == 1 ? 16'hffff :
                     g == 2 ? 16'h001f : 16'h00ff), 8'(g)};
        end
        d = $urandom & 32'h003f1f0f;
        d[3:0] = 4'h6 + 4'($urandom % 10);
        apb(`GCG_SETUP_OFF, 1'b1, d, 4'hf, 33'h0);
        apb(`GCG_SETUP_OFF, 1'b0, 32'h0, 4'hf, {29'h0, d[3:0]});
        apb(`GCG_DIV_OFF, 1'b1, d, 4'hf, 33'h0);
        apb(`GCG_DIV_OFF, 1'b0, 32'h0, 4'hf, {29'h0, d[3:0]});
        apb(12'h00c, 1'b1, $urandom, 4'hf, {1'b1, 32'h0});
        apb(12'h000, 1'b0, 32'h0, 4'hf, {1'b1, 32'h0});
        rd_all();
        // ------------------------------------------------------------
        // user reset spares the clock and locked generators, except generator 0
        // ------------------------------------------------------------
        r = 1 + $urandom % 5;
        rtc_generator <= 4'(r);
        write_lock_source <= 6'($urandom);
        @(posedge pclk);
        user_reset <= 1'b1;
        @(posedge pclk);
        user_reset <= 1'b0;
        for (int g = 0; g < 6; g++)
            if (g == 0 || (g != r && !write_lock_source[g])) begin
                es[g] = dflt(g);
                ed[g] = 32'(g);
            end
        rd_all();
        power_reset();
        rd_all();
        // ------------------------------------------------------------
        // generator 3 on source code 4, output to its pad
        // ------------------------------------------------------------
        for (int i = 0; i < 5; i++) begin
            apb(`GCG_DIV_OFF, 1'b1, {16'h0, fac[i], 8'h03}, 4'hf, 33'h0);
            apb(`GCG_SETUP_OFF, 1'b1, {11'h0, i == 1 || i == 2, 1'b1, i == 4,
                i == 3, i != 4, 3'h0, 5'h04, 8'h03}, 4'hf, 33'h0);
            repeat (200) @(posedge pclk);
            {rg, rp, hi, lg, lp} = '0;
            repeat (1536) begin
                @(posedge pclk);
                if (gen_clk[3] && !lg) rg++;
                if (pin_out[3] && !lp) rp++;
                hi += int'(gen_clk[3]);
                lg = gen_clk[3];
                lp = pin_out[3];
            end
            e = rat[i] != 0 ? 1536 / (16 * rat[i]) : 0;
            check("rises", 33'(rg > e - 2 && rg < e + 2), 33'h1);
            check("pin", 33'(rp > e - 2 && rp < e + 2), 33'h1);
            e = rat[i] != 0 ? 768 : 0;
            check("high", 33'(hi >= e - 64 && hi <= e + 64), 33'h1);
            if (i == 4) check("idle", 33'(pin_out[3]), 33'h1);
        end
        check("idle0", 33'(pin_out[0]), 33'h0);
        apb(`GCG_SETUP_OFF, 1'b1, 32'h00090103, 4'hf, 33'h0);
        repeat (8) @(posedge pclk);
        check("oe_n", 33'(pin_oe_n[3]), 33'h1);
        conclude();
    end
endmodule
`default_nettype wire
